// [rtl/lcdstp_timing_ctrl.sv]
// lcd row scan timing, polarity, output latch and power control
// What this block does
// R1 - derive line-step and latch-load strobes from the display clock
// R2 - capture each pixel line into the output latch, then drive segments
// R3 - fetch display lines on a path separate from host memory writes
// R4 - generate common scan timing and the drive polarity from the display clock
// R5 - polarity toggles once per frame, so it alternates over two frames
// R6 - scan direction bit: ascend from common 0 or descend from last common
// R7 - 197 driver channels, each choosing one of four levels
// R8 - level from latched pixel, active common and polarity
// R9 - supply circuit enables only pass when configured as master
// R10 - 3-bit power field switches booster, regulator, follower independently
// R11 - bit 2 booster, bit 1 regulator, bit 0 follower; 1 means on
// R12 - host should use only all-on, regulator+follower, follower, all-off
// R13 - 64-level electronic volume scales the regulated drive voltage
// R14 - 6-bit volume, code 0 most attenuation, code 63 least
// R15 - 3-bit regulator ratio selects one of eight gains
// R16 - scan wraps after last common of the duty plus the icon common
// R17 - after reset all three power bits are cleared
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module lcdstp_timing_ctrl (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic DCLK,
    input wire lcdstp_pkg::lcdstp_bus_s BUS_REQ,
    output logic [7:0] RD_DATA,
    output logic LINE_STROBE,
    output logic LATCH_STROBE,
    output logic FRAME_POLARITY_SIGNAL,
    output logic [6:0] COM_ACTIVE,
    output lcdstp_pkg::lcdstp_pwr_s POWER_EN,
    output logic [5:0] VOLUME_CODE,
    output logic [5:0] EV_ALPHA,
    output logic [2:0] RATIO_CODE,
    output lcdstp_pkg::lcdstp_level_e [lcdstp_pkg::NUM_CH-1:0] DRV_LEVEL
);
    import lcdstp_pkg::*;

    typedef struct packed {
        logic dclk_q;
        logic [3:0] dclk_cnt;
        logic [6:0] step;
        logic pol;
        logic line_stb;
        logic latch_stb;
        logic fetch_on;
        logic [7:0] fetch_col;
        logic rd_pend;
        logic [7:0] rd_col;
        logic [NUM_SEG-1:0] line_buf;
        logic [NUM_SEG-1:0] out_latch;
        logic [6:0] act_com;
        lcdstp_level_e [NUM_CH-1:0] drv;
        logic [2:0] duty;
        logic rev;
        logic master;
        logic [2:0] pwr;
        lcdstp_pwr_s pwr_en;
        logic [5:0] vol;
        logic [2:0] ratio;
        logic [3:0] page;
        logic [7:0] col;
        logic [7:0] rd_data;
    } lcdstp_state_s;

    lcdstp_state_s st_reg;
    lcdstp_state_s st_next;

    logic [6:0] last_com;
    logic [6:0] step_after;
    logic [6:0] fetch_row;
    logic dclk_rise;
    logic line_end;
    logic mem_we;
    logic [ADDR_W-1:0] host_addr;
    logic [ADDR_W-1:0] fetch_addr;
    logic [7:0] mem_rd;
    lcdstp_level_e [NUM_CH-1:0] drv_calc;

    assign last_com = lcdstp_last_com(st_reg.duty);
    assign step_after = lcdstp_next_step(st_reg.step, last_com);
    // the line being fetched is the one shown after the next line end
    assign fetch_row = (step_after > last_com) ? COM_ICON : step_after;
    assign dclk_rise = DCLK & ~st_reg.dclk_q;
    assign line_end = dclk_rise && (st_reg.dclk_cnt == DCLK_PER_LINE - 4'h1); // R1
    assign host_addr = ADDR_W'(st_reg.page) * ADDR_W'(NUM_SEG) + ADDR_W'(st_reg.col);
    assign fetch_addr = ADDR_W'(fetch_row[6:3]) * ADDR_W'(NUM_SEG)
                      + ADDR_W'(st_reg.fetch_col);

    // host writes and display reads use separate ports, so host traffic
    // never stalls or corrupts the line being fetched
    lcdstp_pix_mem u_mem ( // R3
        .clk(CLK_SYS),
        .wr_en(mem_we),
        .wr_addr(host_addr),
        .wr_data(BUS_REQ.wdata),
        .rd_addr(fetch_addr),
        .rd_data(mem_rd)
    );

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch // R7
        if (ch < NUM_COM) begin : g_com
            assign drv_calc[ch] = lcdstp_com_lvl(st_reg.act_com == 7'(ch), st_reg.pol); // R8
        end else begin : g_seg
            assign drv_calc[ch] = lcdstp_seg_lvl(st_reg.out_latch[ch - NUM_COM],
                                                 st_reg.pol); // R8
        end
    end

    always_comb begin
        st_next = st_reg;
        mem_we = 1'b0;
        st_next.dclk_q = DCLK;
        st_next.line_stb = 1'b0;
        st_next.latch_stb = st_reg.line_stb;
        st_next.drv = drv_calc; // R2
        if (dclk_rise) begin
            st_next.dclk_cnt = line_end ? 4'h0 : st_reg.dclk_cnt + 4'h1;
        end
        if (line_end) begin
            st_next.step = step_after; // R16
            st_next.out_latch = st_reg.line_buf; // R2
            st_next.act_com = lcdstp_com_of(step_after, last_com, st_reg.rev); // R4 R6
            st_next.line_stb = 1'b1; // R1
            if (step_after == 7'h00) begin
                st_next.pol = ~st_reg.pol; // R5
            end
            st_next.fetch_on = 1'b1;
            st_next.fetch_col = 8'h00;
        end else if (st_reg.fetch_on) begin
            st_next.fetch_col = st_reg.fetch_col + 8'h01;
            if (st_reg.fetch_col == COL_LAST) begin
                st_next.fetch_on = 1'b0;
            end
        end
        // no read is issued in the line-end cycle: the row is about to change
        st_next.rd_pend = st_reg.fetch_on && !line_end;
        st_next.rd_col = st_reg.fetch_col;
        if (st_reg.rd_pend) begin
            st_next.line_buf[st_reg.rd_col] = mem_rd[fetch_row[2:0]]; // R2
        end

        if (BUS_REQ.wr) begin
            if (BUS_REQ.addr == OFS_SCAN) begin
                st_next.duty = BUS_REQ.wdata[2:0]; // R16
                st_next.rev = BUS_REQ.wdata[SCAN_REV]; // R6
                st_next.master = BUS_REQ.wdata[SCAN_MASTER];
            end else if (BUS_REQ.addr == OFS_PWR) begin
                st_next.pwr = BUS_REQ.wdata[2:0]; // R10
            end else if (BUS_REQ.addr == OFS_VOL) begin
                st_next.vol = BUS_REQ.wdata[5:0]; // R13 R14
            end else if (BUS_REQ.addr == OFS_RATIO) begin
                st_next.ratio = BUS_REQ.wdata[2:0]; // R15
            end else if (BUS_REQ.addr == OFS_PAGE) begin
                st_next.page = BUS_REQ.wdata[3:0];
            end else if (BUS_REQ.addr == OFS_COL) begin
                st_next.col = BUS_REQ.wdata;
            end else if (BUS_REQ.addr == OFS_PIX) begin
                // out-of-range page or column is dropped, not wrapped
                mem_we = (st_reg.page <= PAGE_ICON) && (st_reg.col <= COL_LAST);
                if (st_reg.col < COL_LAST) begin
                    st_next.col = st_reg.col + 8'h01;
                end
            end
        end

        // power enables follow the stored field only in master operation
        st_next.pwr_en.boost = st_next.master & st_next.pwr[PWR_BOOST]; // R9 R11
        st_next.pwr_en.regul = st_next.master & st_next.pwr[PWR_REGUL]; // R9 R11
        st_next.pwr_en.follow = st_next.master & st_next.pwr[PWR_FOLLOW]; // R9 R11

        st_next.rd_data = 8'h00;
        if (BUS_REQ.rd) begin
            if (BUS_REQ.addr == OFS_SCAN) begin
                st_next.rd_data = {3'h0, st_reg.master, st_reg.rev, st_reg.duty};
            end else if (BUS_REQ.addr == OFS_PWR) begin
                st_next.rd_data = {5'h00, st_reg.pwr};
            end else if (BUS_REQ.addr == OFS_VOL) begin
                st_next.rd_data = {2'h0, st_reg.vol};
            end else if (BUS_REQ.addr == OFS_RATIO) begin
                st_next.rd_data = {5'h00, st_reg.ratio};
            end else if (BUS_REQ.addr == OFS_PAGE) begin
                st_next.rd_data = {4'h0, st_reg.page};
            end else if (BUS_REQ.addr == OFS_COL) begin
                st_next.rd_data = st_reg.col;
            end else if (BUS_REQ.addr == OFS_STAT) begin
                st_next.rd_data = {st_reg.pol, st_reg.act_com};
            end
        end
    end

    // reset clears power bits and starts at step 0 with normal scan
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= '0; // R17
        end else begin
            st_reg <= st_next;
        end
    end

    assign RD_DATA = st_reg.rd_data;
    assign LINE_STROBE = st_reg.line_stb;
    assign LATCH_STROBE = st_reg.latch_stb;
    assign FRAME_POLARITY_SIGNAL = st_reg.pol;
    assign COM_ACTIVE = st_reg.act_com;
    assign POWER_EN = st_reg.pwr_en;
    assign VOLUME_CODE = st_reg.vol;
    // code 0 gives the largest attenuation step
    assign EV_ALPHA = ~st_reg.vol; // R14
    assign RATIO_CODE = st_reg.ratio;
    assign DRV_LEVEL = st_reg.drv;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    a_latch_after_line: assert property (LINE_STROBE |=> LATCH_STROBE && !LINE_STROBE) // R1
        else $error("latch strobe did not follow line strobe");

    a_latch_loads_buf: assert property ( // R2
        LINE_STROBE |-> st_reg.out_latch == $past(st_reg.line_buf))
        else $error("output latch not loaded from fetched line");

    a_latch_host_stable: assert property (!LINE_STROBE |-> $stable(st_reg.out_latch)) // R3
        else $error("output latch changed outside a line strobe");

    a_pol_frame_toggle: assert property ( // R5
        LINE_STROBE && st_reg.step == 7'h00
        |-> FRAME_POLARITY_SIGNAL != $past(FRAME_POLARITY_SIGNAL))
        else $error("polarity did not toggle at frame start");

    a_pol_line_hold: assert property ( // R4
        LINE_STROBE && st_reg.step != 7'h00 |-> $stable(FRAME_POLARITY_SIGNAL))
        else $error("polarity changed inside a frame");

    // duty and direction as they stood when the step was taken
    a_scan_dir: assert property ( // R6
        LINE_STROBE && st_reg.step <= $past(last_com)
        |-> COM_ACTIVE == ($past(st_reg.rev) ? $past(last_com) - st_reg.step : st_reg.step))
        else $error("common scan order wrong for direction");

    a_scan_wrap: assert property ( // R16
        LINE_STROBE && $past(st_reg.step) > $past(last_com)
        |-> st_reg.step == 7'h00 && COM_ACTIVE != COM_ICON)
        else $error("scan did not wrap after the icon common");

    a_drv_from_latch: assert property ( // R8
        LATCH_STROBE
        |-> DRV_LEVEL[NUM_COM] == lcdstp_seg_lvl(st_reg.out_latch[0], FRAME_POLARITY_SIGNAL))
        else $error("segment level does not match latch and polarity");

    a_power_slave_off: assert property (!st_reg.master |-> POWER_EN == 3'h0) // R9
        else $error("supply enabled while not master");

    a_power_write: assert property ( // R10 R11
        BUS_REQ.wr && BUS_REQ.addr == OFS_PWR && !BUS_REQ.rd ##1 st_reg.master
        |-> POWER_EN == $past(BUS_REQ.wdata[2:0]))
        else $error("power field not applied bit for bit");

    a_volume_write: assert property ( // R13 R14
        BUS_REQ.wr && BUS_REQ.addr == OFS_VOL
        |=> VOLUME_CODE == $past(BUS_REQ.wdata[5:0]) && EV_ALPHA == 6'h3F - VOLUME_CODE)
        else $error("volume code or attenuation wrong after write");

    a_ratio_write: assert property ( // R15
        BUS_REQ.wr && BUS_REQ.addr == OFS_RATIO |=> RATIO_CODE == $past(BUS_REQ.wdata[2:0]))
        else $error("ratio code not stored");

    c_frame_wrap: cover property (LINE_STROBE && st_reg.step == 7'h00);
    c_reverse_line: cover property (LINE_STROBE && st_reg.rev && st_reg.step == 7'h00);
    c_icon_line: cover property (LINE_STROBE && COM_ACTIVE == COM_ICON);
    c_power_all_on: cover property (POWER_EN == 3'h7);
endmodule

// [inc/lcdstp_pkg.sv]
// constants, types and helpers shared by the lcd scan timing block
package lcdstp_pkg;
    localparam int NUM_SEG = 132;
    localparam int NUM_COM = 65;
    localparam int NUM_CH = NUM_SEG + NUM_COM;
    localparam int MEM_WORDS = 1188;
    localparam int ADDR_W = 11;
    localparam logic [7:0] COL_LAST = 8'h83;
    localparam logic [3:0] PAGE_ICON = 4'h8;
    localparam logic [6:0] COM_ICON = 7'h40;
    localparam logic [3:0] DCLK_PER_LINE = 4'h4;
    localparam logic [6:0] LAST_65 = 7'h3F;
    localparam logic [6:0] LAST_49 = 7'h2F;
    localparam logic [6:0] LAST_33 = 7'h1F;
    localparam logic [6:0] LAST_55 = 7'h35;
    localparam logic [6:0] LAST_53 = 7'h33;
    localparam logic [7:0] OFS_SCAN = 8'h00;
    localparam logic [7:0] OFS_PWR = 8'h01;
    localparam logic [7:0] OFS_VOL = 8'h02;
    localparam logic [7:0] OFS_RATIO = 8'h03;
    localparam logic [7:0] OFS_PAGE = 8'h04;
    localparam logic [7:0] OFS_COL = 8'h05;
    localparam logic [7:0] OFS_PIX = 8'h06;
    localparam logic [7:0] OFS_STAT = 8'h07;
    localparam int SCAN_REV = 3;
    localparam int SCAN_MASTER = 4;
    localparam int PWR_BOOST = 2;
    localparam int PWR_REGUL = 1;
    localparam int PWR_FOLLOW = 0;

    typedef enum logic [2:0] {DUTY_65, DUTY_49, DUTY_33, DUTY_55, DUTY_53} lcdstp_duty_e;
    typedef enum logic [1:0] {LVL_TOP, LVL_UPPER, LVL_LOWER, LVL_BOTTOM} lcdstp_level_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcdstp_bus_s;

    typedef struct packed {
        logic boost;
        logic regul;
        logic follow;
    } lcdstp_pwr_s;

    // unused duty codes fall back to the full panel
    function automatic logic [6:0] lcdstp_last_com(input logic [2:0] duty);
        case (lcdstp_duty_e'(duty))
            DUTY_49: return LAST_49;
            DUTY_33: return LAST_33;
            DUTY_55: return LAST_55;
            DUTY_53: return LAST_53;
            default: return LAST_65;
        endcase
    endfunction

    // step last+1 is the icon common
    function automatic logic [6:0] lcdstp_next_step(input logic [6:0] step, input logic [6:0] last);
        return (step > last) ? 7'h00 : step + 7'h01;
    endfunction

    function automatic logic [6:0] lcdstp_com_of(input logic [6:0] step, input logic [6:0] last,
                                                 input logic rev);
        if (step > last) begin
            return COM_ICON;
        end
        return rev ? last - step : step;
    endfunction

    // selected pixel: segment and common sit at opposite extremes
    function automatic lcdstp_level_e lcdstp_seg_lvl(input logic pix, input logic pol);
        if (pix) begin
            return pol ? LVL_BOTTOM : LVL_TOP;
        end
        return pol ? LVL_UPPER : LVL_LOWER;
    endfunction

    function automatic lcdstp_level_e lcdstp_com_lvl(input logic sel, input logic pol);
        if (sel) begin
            return pol ? LVL_TOP : LVL_BOTTOM;
        end
        return pol ? LVL_LOWER : LVL_UPPER;
    endfunction
endpackage

// [rtl/lcdstp_pix_mem.sv]
// two-port pixel memory, host write port and display read port
`timescale 1ns/1ps
module lcdstp_pix_mem (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [lcdstp_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [lcdstp_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import lcdstp_pkg::*;

    logic [7:0] mem [MEM_WORDS];

    // no reset: pixel content is undefined until the host writes it
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// [sim/lcdstp_panel_model.sv]
// panel electrode model: a pixel shows lit when segment and active common sit at opposite extremes
`timescale 1ns/1ps
module lcdstp_panel_model #(
    parameter int SEG_CH = 65
) (
    input wire lcdstp_pkg::lcdstp_level_e [lcdstp_pkg::NUM_CH-1:0] drv,
    output logic lit
);
    import lcdstp_pkg::*;
    // passive load, the panel never drives back into the block
    always_comb begin
        lit = 1'b0;
        for (int i = 0; i < NUM_COM; i++) begin
            if ((drv[i] == LVL_TOP && drv[SEG_CH] == LVL_BOTTOM) ||
                (drv[i] == LVL_BOTTOM && drv[SEG_CH] == LVL_TOP)) begin
                lit = 1'b1;
            end
        end
    end
endmodule

// [sim/lcdstp_timing_ctrl_tb.sv]
// self-checking bench for the lcd scan timing and power control block
`timescale 1ns/1ps
module lcdstp_timing_ctrl_tb;
    import lcdstp_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    logic dclk = 0;
    lcdstp_bus_s req = '0;
    logic [7:0] rd_data;
    logic line_stb, latch_stb, pol, lit_on, lit_off, was_rd;
    logic [6:0] com;
    lcdstp_pwr_s pwr;
    logic [5:0] vol, alpha;
    logic [2:0] ratio;
    lcdstp_level_e [NUM_CH-1:0] drv;
    int fails = 0;
    int total_checks = 0;
    int dcnt = 0;
    int rises = 0;
    int lines = 0;
    logic [7:0] rd_q[$];
    logic [7:0] line_q[$];
    logic [7:0] cur = '0;
    logic [7:0] v;
    logic [6:0] step = '0;
    logic [6:0] last = LAST_65;
    logic [6:0] lasts[5] = '{LAST_65, LAST_49, LAST_33, LAST_55, LAST_53};
    logic spol = 0, rev = 0, drv_en = 0, latch_due = 0, dclk_run = 0;

    always #25 clk = ~clk;

    lcdstp_timing_ctrl uut (.CLK_SYS(clk), .RESETN(resetn), .DCLK(dclk), .BUS_REQ(req),
        .RD_DATA(rd_data), .LINE_STROBE(line_stb), .LATCH_STROBE(latch_stb),
        .FRAME_POLARITY_SIGNAL(pol), .COM_ACTIVE(com), .POWER_EN(pwr), .VOLUME_CODE(vol),
        .EV_ALPHA(alpha), .RATIO_CODE(ratio), .DRV_LEVEL(drv));
    lcdstp_panel_model #(.SEG_CH(70)) panel_on (.drv(drv), .lit(lit_on));
    lcdstp_panel_model #(.SEG_CH(71)) panel_off (.drv(drv), .lit(lit_off));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
    endtask

    task automatic wait_lines(input int n);
        int t;
        t = lines + n;
        while (lines < t) @(posedge clk);
        #2;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // display clock: 144 system cycles a line leaves room for the line fetch;
    // held low until the pixel memory holds no unknown byte
    always @(posedge clk) begin
        if (resetn && dclk_run) begin
            dcnt++;
            if (dcnt == 18) begin
                dcnt = 0;
                dclk <= ~dclk;
                if (!dclk) begin
                    rises++;
                    if (rises % 4 == 0) begin
                        step = (step > last) ? 7'h00 : step + 7'h01;
                        if (step == 7'h00) spol = ~spol;
                        line_q.push_back({spol, (step > last) ? COM_ICON :
                            (rev ? last - step : step)});
                    end
                end
            end
        end
    end

    always @(posedge clk) begin
        was_rd = req.rd;
        #1;
        if (was_rd) chk("read data", rd_q.pop_front(), rd_data);
        if (latch_due) begin
            chk("latch strobe", 8'h01, {7'h0, latch_stb});
            if (drv_en) begin
                chk("seg on", 8'(cur[7] ? LVL_BOTTOM : LVL_TOP), 8'(drv[70]));
                chk("seg off", 8'(cur[7] ? LVL_UPPER : LVL_LOWER), 8'(drv[71]));
                chk("com sel", 8'(cur[7] ? LVL_TOP : LVL_BOTTOM), 8'(drv[cur[6:0]]));
                chk("com idle", 8'(cur[7] ? LVL_LOWER : LVL_UPPER),
                    8'(drv[cur[6:0] == 7'h00 ? 1 : 0]));
                chk("panel lit", 8'h01, {7'h0, lit_on});
                chk("panel dark", 8'h00, {7'h0, lit_off});
            end
        end
        latch_due = line_stb;
        if (line_stb) begin
            lines++;
            cur = line_q.size() > 0 ? line_q.pop_front() : 8'hFF;
            chk("line status", cur, {pol, com});
        end
    end

    initial begin
        void'($urandom(32'h965A));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk("power reset", 8'h00, {5'h0, pwr});
        chk("volume reset", 8'h00, {2'h0, vol});
        chk("alpha reset", 8'h3F, {2'h0, alpha});
        chk("ratio reset", 8'h00, {5'h0, ratio});
        $display("test reset done");
        last = LAST_33;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_SCAN, m ? 8'h12 : 8'h02);
            // every pattern, the discouraged ones too
            for (int p = 0; p < 8; p++) begin
                wr(OFS_PWR, 8'(p));
                chk("power enables", m ? 8'(p) : 8'h00, {5'h0, pwr});
            end
        end
        $display("test power done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h3F : 8'($urandom);
            wr(OFS_VOL, v);
            wr(OFS_RATIO, v);
            chk("volume", {2'h0, v[5:0]}, {2'h0, vol});
            chk("alpha", {2'h0, ~v[5:0]}, {2'h0, alpha});
            chk("ratio", {5'h0, v[2:0]}, {5'h0, ratio});
        end
        rd(8'hF0, 8'h00);
        rd(OFS_PIX, 8'h00);
        $display("test registers done");
        // every byte written before the first fetch, so no unknown pixel reaches the latch;
        // lit column 5 and dark column 6 in every row, icon row included
        for (int pg = 0; pg < 9; pg++) begin
            wr(OFS_PAGE, 8'(pg));
            wr(OFS_COL, 8'h00);
            for (int c = 0; c < NUM_SEG; c++) begin
                wr(OFS_PIX, (c == 5) ? 8'hFF : 8'h00);
            end
        end
        dclk_run <= 1'b1;
        wait_lines(3);
        drv_en = 1'b1;
        for (int i = 0; i < 10; i++) begin
            wait_lines(1);
            rev = i[0];
            last = lasts[i / 2];
            wr(OFS_SCAN, {3'h0, 1'b1, rev, 3'(i / 2)});
            rd(OFS_STAT, cur);
            wait_lines(i[0] ? int'(last) + 3 : 20);
            $display("test scan %0d done", i);
        end
        final_report();
    end

    initial begin
        #(80_000 * 50);
        fails++;
        final_report();
    end
endmodule
